/* cgsp_port.sv */
// Purpose: Two-wire serial target and configuration bytes 0 to 3.
// Assumes: Host keeps standard-mode timing; 20 MHz clock samples the lines.
// Notes: Data line is open drain; only a low level is ever driven.
// Operation
// - Write address D2 is acknowledged.
// - Read address D3 is acknowledged.
// - Command and count acknowledged, then discarded.
// - Data fills bytes upward from 0, each acknowledged.
// - Loading stops after byte 3; later bytes acknowledged, then dropped.
// - Only block writes, no indexed access.
// - Read sends byte count first.
// - Read then returns bytes 0 through 6.
// - Up to 100 kbit/s, eight-bit bytes.
// - Registers take defaults at power-on.
// - Byte 0 bit 7 enables spread spectrum.
// - Byte 0 bit 6 selects power-down level.
// - Byte 0 bit 5 selects shared output rate.
// - Byte 0 bit 4 mirrors CPU stop pin.
// - Byte 0 bit 3 caught from PCI stop.
// - Byte 0 bits 2-0 caught from frequency pins.
// - Byte 1 pin bit and stop level.
// - Byte 1 bits 5-3 make CPU pairs free-running.
// - Byte 3 bits 5-3 make free PCI stoppable.
// - Per-output enable bits, all reset to one.
// - Stoppable CPU pairs stop on CPU stop.
// - PCI outputs stop low on PCI stop.
`timescale 1ns/100ps
module cgsp_port
  import cgsp_pkg::*;
(
  input wire logic mclk, // System clock, 20 MHz.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic scl_in, // Serial clock from the host.
  input wire logic sda_in, // Serial data line level.
  output logic sda_out, // Level driven on the data line, always low.
  output logic sda_oe, // High while the data line is pulled low.
  input wire logic cpu_stop_n, // CPU stop pin, low stops.
  input wire logic pci_stop_n, // PCI stop pin, low stops.
  input wire logic power_off_n, // Power-down pin, low powers down.
  input wire logic current_mult_select, // Current multiplier pin.
  input wire logic freq_sel_hi, // Frequency select pin 2.
  input wire logic freq_sel_mid, // Frequency select pin 1.
  input wire logic freq_sel_lo, // Frequency select pin 0.
  output cgsp_regs_t cfg, // Configuration bytes 0 to 3.
  output cgsp_gate_t gates // Run gates for the output stage.
);

  // Serial engine states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK,
    ST_SKIP
  } cgsp_state_t;

  // Returns the byte sent back for read index idx.
  function automatic logic [7:0] rd_byte(input logic [3:0] idx,
                                         input cgsp_regs_t r);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      4'h0: v = r.b0;
      4'h1: v = r.b1;
      4'h2: v = r.b2;
      4'h3: v = r.b3;
      IDX_ID: v = ID_BYTE;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Merges a write into a byte, keeping its read-only bits.
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wd,
                                       input logic [7:0] mask);
    return (old & ~mask) | (wd & mask);
  endfunction

  cgsp_state_t state_reg; // Serial engine state.
  logic [8:0] meta_reg; // First synchroniser stage.
  logic [8:0] sync_reg; // Second synchroniser stage.
  logic scl_d_reg; // Serial clock one cycle later.
  logic sda_d_reg; // Serial data one cycle later.
  logic [7:0] shift_reg; // Incoming byte.
  logic [7:0] tx_reg; // Outgoing byte.
  logic [3:0] bit_reg; // Bits seen in the current byte.
  logic [3:0] idx_reg; // Byte position within the transfer.
  logic rd_reg; // Current transfer is a read.
  logic sda_oe_reg; // Data line pull-down.
  cgsp_regs_t cfg_reg; // Configuration bytes.
  cgsp_gate_t gates_reg; // Output run gates.
  logic [1:0] strap_cnt_reg; // Cycles since reset release.
  logic strap_done_reg; // Pin straps have been caught.
  cgsp_wr_t buf_reg [2]; // Two-entry write buffer.
  logic wptr_reg; // Buffer write pointer.
  logic rptr_reg; // Buffer read pointer.
  logic [1:0] cnt_reg; // Buffer fill level.

  // Names for the synchronised pins.
  logic scl_s, sda_s, cstop_s, pstop_s, poff_s, mult_s;
  logic [2:0] fs_s;
  assign scl_s = sync_reg[0];
  assign sda_s = sync_reg[1];
  assign cstop_s = sync_reg[2];
  assign pstop_s = sync_reg[3];
  assign poff_s = sync_reg[4];
  assign mult_s = sync_reg[5];
  assign fs_s = sync_reg[8:6];

  // Line events seen through the synchronisers.
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
  assign stop_det = scl_s & scl_d_reg & sda_s & ~sda_d_reg;

  // Buffer handshake terms.
  logic in_valid, in_ready, out_valid, out_ready;
  logic byte_end, data_pos;
  cgsp_wr_t in_item, out_item;
  logic [7:0] tx_next; // Byte that the next read slot sends back.
  assign tx_next = rd_byte(idx_reg, cfg_reg);
  assign byte_end = scl_fall & (bit_reg == 4'h8);
  // Only positions 2 to 5 carry register data; 0 and 1 are dropped.
  assign data_pos = (idx_reg >= 4'h2) & (idx_reg <= 4'h5);
  assign in_ready = (cnt_reg != 2'h2);
  assign in_valid = (state_reg == ST_WBYTE) & byte_end & data_pos;
  assign in_item.idx = 2'(idx_reg - 4'h2);
  assign in_item.data = shift_reg;
  assign out_valid = (cnt_reg != 2'h0);
  assign out_item = buf_reg[rptr_reg];
  // Draining pauses while a read byte is loaded, so the snapshot is clean.
  // It also waits for the strap capture, which would otherwise swallow it.
  assign out_ready = strap_done_reg & ~((state_reg == ST_RACK) & scl_fall);

  // Two flip-flops on every pin before any logic looks at it.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_reg <= 9'h1FF;
      sync_reg <= 9'h1FF;
    end else begin
      meta_reg <= {freq_sel_hi, freq_sel_mid, freq_sel_lo,
                   current_mult_select, power_off_n, pci_stop_n,
                   cpu_stop_n, sda_in, scl_in};
      sync_reg <= meta_reg;
    end
  end

  // Delayed copies for edge and condition detection.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Serial engine: bits are taken on the rising clock, driven on falling.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      bit_reg <= 4'h0;
      idx_reg <= 4'h0;
      rd_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      // A start, repeated or not, always restarts address reception.
      state_reg <= ST_ADDR;
      bit_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      // Stop ends any transfer; writes load bytes 0 to 3 only.
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_WBYTE: begin
          if (scl_rise && bit_reg != 4'h8) begin
            // Eight-bit bytes, most significant bit first.
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_reg <= bit_reg + 4'h1;
          end else if (byte_end && state_reg == ST_ADDR) begin
            if (shift_reg == ADDR_WR || shift_reg == ADDR_RD) begin
              sda_oe_reg <= 1'b1;
              rd_reg <= shift_reg[0];
              state_reg <= ST_AACK;
            end else begin
              state_reg <= ST_SKIP;
            end
          end else if (byte_end) begin
            // Command and count are acknowledged unconditionally.
            if (!data_pos || in_ready) begin
              sda_oe_reg <= 1'b1;
              state_reg <= ST_WACK;
            end else begin
              // A full buffer cannot take the byte: refuse it.
              state_reg <= ST_SKIP;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_reg <= 4'h0;
            idx_reg <= 4'h0;
            if (rd_reg) begin
              // The byte count leads every read.
              tx_reg <= BYTE_COUNT;
              sda_oe_reg <= ~BYTE_COUNT[7];
              state_reg <= ST_RBYTE;
            end else begin
              // Writes always begin with the command byte.
              sda_oe_reg <= 1'b0;
              state_reg <= ST_WBYTE;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            bit_reg <= 4'h0;
            // Position saturates; bytes past the last are acknowledged.
            if (idx_reg != 4'hF) begin
              idx_reg <= idx_reg + 4'h1;
            end
            state_reg <= ST_WBYTE;
          end
        end
        ST_RBYTE: begin
          if (scl_fall) begin
            if (bit_reg == 4'h7) begin
              sda_oe_reg <= 1'b0; // Release for the host's answer.
              state_reg <= ST_RACK;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
              bit_reg <= bit_reg + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s) begin
            // No acknowledge: the host is done reading.
            state_reg <= ST_SKIP;
          end else if (scl_fall) begin
            // Next byte in order, 0 through 6, zeros after.
            tx_reg <= tx_next;
            sda_oe_reg <= ~tx_next[7];
            bit_reg <= 4'h0;
            if (idx_reg != 4'hF) begin
              idx_reg <= idx_reg + 4'h1;
            end
            state_reg <= ST_RBYTE;
          end
        end
        ST_SKIP: begin
          sda_oe_reg <= 1'b0; // Line stays released until stop.
        end
        ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Write buffer: the serial side fills, the register file drains.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
    end else begin
      if (in_valid && in_ready) begin
        buf_reg[wptr_reg] <= in_item;
        wptr_reg <= ~wptr_reg;
      end
      if (out_valid && out_ready) begin
        rptr_reg <= ~rptr_reg;
      end
      cnt_reg <= cnt_reg + 2'(in_valid && in_ready)
                 - 2'(out_valid && out_ready);
    end
  end

  // Strap timer: pins are caught once the synchronisers hold real values.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      strap_done_reg <= (strap_cnt_reg == STRAP_DELAY);
    end
  end

  // Register file: defaults, strap capture, live pins and writes.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_reg.b0 <= B0_RST;
      cfg_reg.b1 <= B1_RST;
      cfg_reg.b2 <= B2_RST;
      cfg_reg.b3 <= B3_RST;
    end else begin
      if (!strap_done_reg && strap_cnt_reg == STRAP_DELAY) begin
        cfg_reg.b0[B0_PCI_STOP] <= pstop_s;
        cfg_reg.b0[B0_FREQ_LO +: 3] <= fs_s;
      end else if (out_valid && out_ready) begin
        case (out_item.idx)
          OFS_SPREAD_FREQ:
            cfg_reg.b0 <= merge(cfg_reg.b0, out_item.data, B0_WMASK);
          OFS_CPU_CTRL:
            cfg_reg.b1 <= merge(cfg_reg.b1, out_item.data, B1_WMASK);
          OFS_PCI_EN:
            cfg_reg.b2 <= merge(cfg_reg.b2, out_item.data, B2_WMASK);
          default:
            cfg_reg.b3 <= merge(cfg_reg.b3, out_item.data, B3_WMASK);
        endcase
      end
      // Read-only bits track their pins every cycle.
      cfg_reg.b0[B0_CPU_STOP] <= cstop_s;
      cfg_reg.b1[B1_MULT] <= mult_s;
    end
  end

  // Output gates; the output stage stops each clock at its next edge.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gates_reg <= '0;
    end else begin
      gates_reg.cpu_run <= cfg_reg.b1[B1_EN_LO +: 3] & {3{poff_s}}
        & (cfg_reg.b1[B1_FREE_LO +: 3] | {3{cstop_s}});
      gates_reg.pci_run <= cfg_reg.b2[6:0] & {7{poff_s & pstop_s}};
      gates_reg.fpci_run <= cfg_reg.b3[B3_FEN_LO +: 3] & {3{poff_s}}
        & (~cfg_reg.b3[B3_FSTOP_LO +: 3] | {3{pstop_s}});
    end
  end

  assign sda_oe = sda_oe_reg;
  assign sda_out = 1'b0;
  assign cfg = cfg_reg;
  assign gates = gates_reg;

  // Checks on the serial engine, the registers and the gates.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_line_stable_high: assert property (
    (scl_s && scl_d_reg && $past(scl_s) && !$past(start_det)
     && !$past(stop_det)) |-> $stable(sda_oe_reg))
    else $error("Data line changed while serial clock high.");
  a_write_addr_ack: assert property (
    (state_reg == ST_ADDR && byte_end && shift_reg == ADDR_WR
     && !start_det && !stop_det) |=> (sda_oe_reg && !rd_reg))
    else $error("Write address not acknowledged.");
  a_read_addr_ack: assert property (
    (state_reg == ST_ADDR && byte_end && shift_reg == ADDR_RD
     && !start_det && !stop_det) |=> (sda_oe_reg && rd_reg))
    else $error("Read address not acknowledged.");
  a_other_addr_nack: assert property (
    (state_reg == ST_ADDR && byte_end && shift_reg != ADDR_WR
     && shift_reg != ADDR_RD && !start_det && !stop_det)
    |=> (!sda_oe_reg && state_reg == ST_SKIP) [*2])
    else $error("Foreign address was answered.");
  a_dummy_dropped: assert property (
    (state_reg == ST_WBYTE && byte_end && idx_reg < 4'h2 && !start_det
     && !stop_det) |=> (cnt_reg <= $past(cnt_reg)))
    else $error("Command or count byte reached a register.");
  a_count_first: assert property (
    (state_reg == ST_AACK && scl_fall && rd_reg && !start_det
     && !stop_det) |=> (tx_reg == BYTE_COUNT && idx_reg == 4'h0))
    else $error("Read did not begin with the byte count.");
  a_reset_values: assert property (
    (strap_cnt_reg == 2'h0 && !strap_done_reg)
    |-> (cfg_reg.b2 == B2_RST && cfg_reg.b1[6:0] == B1_RST[6:0]))
    else $error("Register default missing after reset.");
  a_cpu_stop_gate: assert property (
    (!cstop_s && !cfg_reg.b1[B1_FREE_LO]) |=> !gates_reg.cpu_run[0])
    else $error("Stoppable CPU pair kept running.");
  a_pci_stop_gate: assert property (
    (!pstop_s) |=> (gates_reg.pci_run == 7'h00))
    else $error("PCI outputs kept running during stop.");
  a_cpu_pin_mirror: assert property (
    (strap_done_reg) |=> (cfg_reg.b0[B0_CPU_STOP] == $past(cstop_s)))
    else $error("CPU stop bit does not follow its pin.");

  c_write_data: cover property (in_valid && in_ready);
  c_read_byte: cover property (state_reg == ST_RACK && scl_fall);
  c_buffer_full: cover property (cnt_reg == 2'h2);
  c_foreign_addr: cover property (state_reg == ST_SKIP && stop_det);

endmodule

/* cgsp_pkg.sv */
// Purpose: Shared constants and types for the clock generator serial port.
// Assumes: One 20 MHz system clock; serial lines arrive asynchronously.
// Notes: Register bytes 0 to 3 are held; bytes 4 to 6 read as constants.
package cgsp_pkg;

  // Target address bytes, direction bit included.
  localparam logic [7:0] ADDR_WR = 8'hD2;
  localparam logic [7:0] ADDR_RD = 8'hD3;
  // Byte count returned first in every block read (bytes 0 to 6).
  localparam logic [7:0] BYTE_COUNT = 8'h07;
  // Register bytes 0 to 3 and their byte indices.
  localparam logic [1:0] OFS_SPREAD_FREQ = 2'h0;
  localparam logic [1:0] OFS_CPU_CTRL = 2'h1;
  localparam logic [1:0] OFS_PCI_EN = 2'h2;
  localparam logic [1:0] OFS_USB_DOT_FPCI = 2'h3;
  // Read-back index of the identity byte.
  localparam logic [3:0] IDX_ID = 4'h6;
  // Identity byte value; arbitrary neutral value.
  localparam logic [7:0] ID_BYTE = 8'h11;

  // Byte 0 field positions.
  localparam int B0_SPREAD = 7;
  localparam int B0_PD_LEVEL = 6;
  localparam int B0_VCH_SEL = 5;
  localparam int B0_CPU_STOP = 4;
  localparam int B0_PCI_STOP = 3;
  localparam int B0_FREQ_LO = 0;
  // Byte 1 field positions.
  localparam int B1_MULT = 7;
  localparam int B1_STOP_LEVEL = 6;
  localparam int B1_FREE_LO = 3;
  localparam int B1_EN_LO = 0;
  // Byte 3 field positions.
  localparam int B3_DOT_EN = 7;
  localparam int B3_USB_EN = 6;
  localparam int B3_FSTOP_LO = 3;
  localparam int B3_FEN_LO = 0;

  // Power-on values; pin-sampled bits are loaded just after reset.
  localparam logic [7:0] B0_RST = 8'h08;
  localparam logic [7:0] B1_RST = 8'h07;
  localparam logic [7:0] B2_RST = 8'h7F;
  localparam logic [7:0] B3_RST = 8'hC7;
  // Writable bit masks; other bits are read-only or reserved.
  localparam logic [7:0] B0_WMASK = 8'hEF;
  localparam logic [7:0] B1_WMASK = 8'h7F;
  localparam logic [7:0] B2_WMASK = 8'h7F;
  localparam logic [7:0] B3_WMASK = 8'hFF;

  // Timing: system clock period and serial bit period.
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT_PERIOD_NS = 10000;
  localparam int HALF_BIT_CYC = BIT_PERIOD_NS / 2 / CLK_PERIOD_NS;
  // Cycles after reset release before pin straps are caught.
  localparam logic [1:0] STRAP_DELAY = 2'h2;

  // The four configuration bytes, byte 0 in the low bits.
  typedef struct packed {
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } cgsp_regs_t;

  // One received data byte bound for a register.
  typedef struct packed {
    logic [1:0] idx;
    logic [7:0] data;
  } cgsp_wr_t;

  // Output gates for the clock output stage.
  typedef struct packed {
    logic [2:0] cpu_run;
    logic [6:0] pci_run;
    logic [2:0] fpci_run;
  } cgsp_gate_t;

endpackage

/* cgsp_host.sv */
// Purpose: Behavioural host controller that drives the two-wire link.
// Assumes: Data line has a pull-up; the host only ever pulls it low.
// Notes: Serial clock stays high between frames and runs at 400 ns a bit.
`timescale 1ns/100ps
module cgsp_host
  import cgsp_pkg::*;
(
  input wire logic mclk, // System clock that paces every link edge.
  input wire logic sda_line, // Resolved data line level.
  output logic scl, // Serial clock, high while idle.
  output logic sda_pull // High while the host pulls data low.
);
  // A quarter bit of two cycles keeps the half period at the four cycle
  // floor the target needs, which stresses its sampling the hardest.
  localparam int QTR = 2;

  // Idle link: clock high, data released.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Waits a number of system clock edges.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Start, or repeated start, from either idle or clock low.
  task automatic start_cond();
    tick(QTR);
    sda_pull <= 1'b0;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    sda_pull <= 1'b1;
    tick(QTR);
    scl <= 1'b0;
  endtask

  // Nine bits, MSB first; a 1 in tx releases the line for that bit.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(QTR);
      sda_pull <= ~tx[i];
      tick(QTR);
      scl <= 1'b1;
      tick(QTR);
      rx[i] = sda_line;
      tick(QTR);
      scl <= 1'b0;
    end
  endtask

  // Stop: data rises while the clock is high, then the link rests.
  task automatic stop_cond();
    tick(QTR);
    sda_pull <= 1'b1;
    tick(QTR);
    scl <= 1'b1;
    tick(QTR);
    sda_pull <= 1'b0;
    tick(4 * QTR);
  endtask
endmodule

/* cgsp_port_bench.sv */
// Purpose: Self-checking bench for the serial configuration port.
// Assumes: Pins held inactive between scenarios unless a test moves them.
// Notes: Expected bytes are worked out from the package constants.
`timescale 1ns/100ps
module cgsp_port_bench;
  import cgsp_pkg::*;
  logic mclk; // System clock.
  logic resetn; // Synchronous reset, active low.
  logic cpu_stop_n, pci_stop_n, power_off_n; // Power pins.
  logic current_mult_select, freq_sel_hi, freq_sel_mid, freq_sel_lo;
  logic scl; // Serial clock from the host model.
  logic host_pull; // Host pulls data low.
  logic sda_out, sda_oe; // Target side of the data line.
  wire logic sda_line; // Open-drain line with pull-up.
  cgsp_regs_t cfg; // Register bytes.
  cgsp_gate_t gates; // Output gates.
  int err_count;
  int total_checks;

  // The line is low if either party pulls it.
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~host_pull;

  cgsp_host cgsp_host_i (.mclk(mclk), .sda_line(sda_line), .scl(scl),
    .sda_pull(host_pull));
  cgsp_port cgsp_port_i (.mclk(mclk), .resetn(resetn), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .cpu_stop_n(cpu_stop_n), .pci_stop_n(pci_stop_n),
    .power_off_n(power_off_n), .current_mult_select(current_mult_select),
    .freq_sel_hi(freq_sel_hi), .freq_sel_mid(freq_sel_mid),
    .freq_sel_lo(freq_sel_lo), .cfg(cfg), .gates(gates));

  always #25 mclk = ~mclk;

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Sends one byte; ack is high when the target pulled the ninth bit.
  task automatic send(input logic [7:0] b, output logic ack);
    logic [8:0] rx;
    cgsp_host_i.xfer({b, 1'b1}, rx);
    ack = ~rx[0];
  endtask

  // Block write of the given data bytes after dummy command and count.
  task automatic write_regs(input logic [7:0] d [$]);
    logic ack;
    cgsp_host_i.start_cond();
    send(ADDR_WR, ack);
    check(ack, 1);
    send(8'hFF, ack);
    check(ack, 1);
    send(8'h00, ack);
    check(ack, 1);
    foreach (d[i]) begin
      send(d[i], ack);
      check(ack, 1);
    end
    cgsp_host_i.stop_cond();
  endtask

  // Block read of nine bytes; the host refuses the last one.
  task automatic read_back(input logic [7:0] exp [9]);
    logic ack;
    logic [8:0] rx;
    cgsp_host_i.start_cond();
    send(ADDR_RD, ack);
    check(ack, 1);
    for (int i = 0; i < 9; i++) begin
      cgsp_host_i.xfer({8'hFF, i == 8}, rx);
      check(rx[8:1], exp[i]);
    end
    cgsp_host_i.stop_cond();
  endtask

  // Power-on values with straps: freq 101, both stop pins inactive.
  task automatic t_reset();
    check(sda_oe, 0);
    check(cfg, {B3_RST, B2_RST, 8'h87, B0_RST | 8'h15});
    read_back('{BYTE_COUNT, 8'h1D, 8'h87, B2_RST, B3_RST, 8'h00, 8'h00,
      ID_BYTE, 8'h00});
    $display("test reset done");
  endtask

  // Full write with read-only bits set against the pins, plus a fifth byte.
  task automatic t_write();
    write_regs('{8'h6A, 8'h2B, 8'hD5, 8'h1F, 8'h00});
    check(cfg, {8'h1F, 8'h55, 8'hAB, 8'h7A});
    check(cfg.b1, 8'hAB);
    read_back('{BYTE_COUNT, 8'h7A, 8'hAB, 8'h55, 8'h1F, 8'h00, 8'h00,
      ID_BYTE, 8'h00});
    $display("test write done");
  endtask

  // A stop after byte 0 leaves the other bytes alone.
  task automatic t_partial();
    write_regs('{8'h85});
    check(cfg, {8'h1F, 8'h55, 8'hAB, 8'h95});
    $display("test partial done");
  endtask

  // A foreign address gets no acknowledge and changes nothing.
  task automatic t_badaddr();
    logic ack;
    cgsp_host_i.start_cond();
    send(8'hA0, ack);
    check(ack, 0);
    send(8'h00, ack);
    check(ack, 0);
    cgsp_host_i.stop_cond();
    check(cfg, {8'h1F, 8'h55, 8'hAB, 8'h95});
    $display("test bad address done");
  endtask

  // Stop and power pins against the enables and free-run selections.
  task automatic t_gates();
    check(gates, {3'b011, 7'h55, 3'b111});
    cpu_stop_n <= 1'b0;
    pci_stop_n <= 1'b0;
    repeat (8) @(posedge mclk);
    check(gates, {3'b001, 7'h00, 3'b100});
    check(cfg.b0[B0_CPU_STOP], 0);
    power_off_n <= 1'b0;
    repeat (8) @(posedge mclk);
    check(gates, 0);
    cpu_stop_n <= 1'b1;
    pci_stop_n <= 1'b1;
    power_off_n <= 1'b1;
    current_mult_select <= 1'b0;
    repeat (8) @(posedge mclk);
    check(gates, {3'b011, 7'h55, 3'b111});
    check(cfg.b1[B1_MULT], 0);
    $display("test gates done");
  endtask

  // Watchdog: the whole run needs well under this many cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("watchdog expired");
    give_verdict();
  end

  // Main sequence: reset for five cycles, let straps settle, then test.
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    err_count = 0;
    total_checks = 0;
    cpu_stop_n = 1'b1;
    pci_stop_n = 1'b1;
    power_off_n = 1'b1;
    current_mult_select = 1'b1;
    freq_sel_hi = 1'b1;
    freq_sel_mid = 1'b0;
    freq_sel_lo = 1'b1;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (10) @(posedge mclk);
    t_reset();
    t_write();
    t_partial();
    t_badaddr();
    t_gates();
    give_verdict();
  end
endmodule
